// ==== design/nrec_top.sv ====
// NAND region ECC control: AHB-Lite registers, wait status and parity accumulator
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

module nrec_top (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output      logic [31:0]           hrdata,
  output      logic                  hreadyout,
  output      logic                  hresp,
  input  wire logic                  ext_wait_input,
  input  wire nrec_pkg::nrec_access_t nand_access,
  output      logic                  nand_mode_region_two,
  output      logic                  ecc_running
);
  import nrec_pkg::*;

  // Bus slave state
  nrec_state_t  state_r;          // Data phase tracker
  nrec_state_t  state_nxt;
  logic [7:0]   addr_r;           // Latched word address of current transfer
  logic [7:0]   addr_nxt;
  logic [31:0]  hrdata_r;         // Registered read data
  logic [31:0]  hrdata_nxt;
  logic         hreadyout_r;      // Registered ready
  logic         hreadyout_nxt;
  logic         hresp_r;          // Always OKAY

  // Register state
  logic         nand_mode_r;      // nand_mode_region_two
  logic         nand_mode_nxt;
  logic         ecc_start_r;      // ecc_start_region_two as written
  logic         ecc_start_nxt;
  logic         wide_r;           // 16-bit NAND data path
  logic         wide_nxt;
  logic [11:0]  par_odd_r;        // Odd parity accumulator
  logic [11:0]  par_odd_nxt;
  logic [11:0]  par_even_r;       // Even parity accumulator
  logic [11:0]  par_even_nxt;
  logic [11:0]  row_r;            // Index of the next data unit
  logic [11:0]  row_nxt;

  // Decode helpers
  logic         accept;           // Address phase taken this edge
  logic         wr_now;           // Write data phase completes this edge
  logic         start_write;      // Software writes a 1 to the ECC start bit
  logic         take_unit;        // A data unit feeds the accumulator
  logic [11:0]  odd_terms;        // Odd contributions of the present unit
  logic [11:0]  even_terms;       // Even contributions of the present unit
  logic [31:0]  read_word;        // Word selected by the latched address

  // Address phase accepted only while the bus is ready
  assign accept = hsel && htrans[NREC_HTRANS_ACTIVE] && hready;
  // Write lands at the edge that ends its data phase
  assign wr_now = (state_r == NREC_ST_WRITE) && hready;
  assign start_write = wr_now && (addr_r == NREC_OFS_CONTROL) && hwdata[NREC_BIT_ECC_START];

  // Accumulate only on region two accesses in NAND mode with ECC started
  assign take_unit = nand_access.valid && nand_access.cs2 && nand_mode_r && ecc_start_r;

  // One slice per parity position P1..P2048
  for (genvar n = 0; n < NREC_PAR_BITS; n++) begin : g_par
    nrec_parity_slice #(
      .N (n)
    ) u_slice (
      .data      (nand_access.data),
      .row       (row_r),
      .wide      (wide_r),
      .odd_term  (odd_terms[n]),
      .even_term (even_terms[n])
    );
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    read_word = 32'h0000_0000;
    unique case (addr_r)
      NREC_OFS_CONTROL: begin
        read_word[NREC_BIT_NAND_MODE] = nand_mode_r;
        read_word[NREC_BIT_ECC_START] = ecc_start_r;
      end
      NREC_OFS_STATUS: begin
        // Pin level straight through, no polarity applied
        read_word[NREC_BIT_RAW_WAIT] = ext_wait_input;
      end
      NREC_OFS_PARITY: begin
        // Reserved fields 31..28 and 15..12 stay zero
        read_word[NREC_ODD_LSB +: NREC_PAR_BITS]  = par_odd_r;
        read_word[NREC_EVEN_LSB +: NREC_PAR_BITS] = par_even_r;
      end
      NREC_OFS_CONFIG: begin
        read_word[NREC_BIT_WIDE_PATH] = wide_r;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // Bus slave next state: reads take one wait state, writes none
  always_comb begin
    state_nxt     = state_r;
    addr_nxt      = addr_r;
    hrdata_nxt    = hrdata_r;
    hreadyout_nxt = hreadyout_r;
    unique case (state_r)
      NREC_ST_RDWAIT: begin
        // Sample the register after any earlier write has landed
        hrdata_nxt    = read_word;
        hreadyout_nxt = 1'b1;
        state_nxt     = NREC_ST_RDDONE;
      end
      NREC_ST_IDLE, NREC_ST_RDDONE, NREC_ST_WRITE: begin
        // Ready is high here, so a new address phase may be taken
        if (accept) begin
          addr_nxt = {haddr[7:2], 2'b00};
          if (hwrite) begin
            state_nxt     = NREC_ST_WRITE;
            hreadyout_nxt = 1'b1;
          end else begin
            state_nxt     = NREC_ST_RDWAIT;
            hreadyout_nxt = 1'b0;
          end
        end else begin
          state_nxt     = NREC_ST_IDLE;
          hreadyout_nxt = 1'b1;
        end
      end
    endcase
  end

  // Bus slave registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= NREC_ST_IDLE;
      addr_r      <= 8'h00;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      addr_r      <= addr_nxt;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= hreadyout_nxt;
      hresp_r     <= 1'b0;
    end
  end

  // Control and configuration next values from software writes
  always_comb begin
    nand_mode_nxt = nand_mode_r;
    ecc_start_nxt = ecc_start_r;
    wide_nxt      = wide_r;
    if (wr_now && addr_r == NREC_OFS_CONTROL) begin
      nand_mode_nxt = hwdata[NREC_BIT_NAND_MODE];
      ecc_start_nxt = hwdata[NREC_BIT_ECC_START];
    end
    if (wr_now && addr_r == NREC_OFS_CONFIG) begin
      wide_nxt = hwdata[NREC_BIT_WIDE_PATH];
    end
  end

  // Control and configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nand_mode_r <= NREC_RST_CONTROL[NREC_BIT_NAND_MODE];
      ecc_start_r <= NREC_RST_CONTROL[NREC_BIT_ECC_START];
      wide_r      <= NREC_RST_WIDE;
    end else begin
      nand_mode_r <= nand_mode_nxt;
      ecc_start_r <= ecc_start_nxt;
      wide_r      <= wide_nxt;
    end
  end

  // Parity accumulator: a start write clears it and beats a unit in the same cycle
  always_comb begin
    par_odd_nxt  = par_odd_r;
    par_even_nxt = par_even_r;
    row_nxt      = row_r;
    if (start_write) begin
      // Fresh calculation from an empty accumulator
      par_odd_nxt  = NREC_RST_PARITY;
      par_even_nxt = NREC_RST_PARITY;
      row_nxt      = NREC_RST_ROW;
    end else if (take_unit) begin
      // Columns and rows split by path width inside each slice
      par_odd_nxt  = par_odd_r ^ odd_terms;
      par_even_nxt = par_even_r ^ even_terms;
      row_nxt      = row_r + 12'h001;
    end
  end

  // Parity accumulator registers; software writes load them only by clearing them through the ECC start bit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      par_odd_r  <= NREC_RST_PARITY;
      par_even_r <= NREC_RST_PARITY;
      row_r      <= NREC_RST_ROW;
    end else begin
      par_odd_r  <= par_odd_nxt;
      par_even_r <= par_even_nxt;
      row_r      <= row_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign hrdata               = hrdata_r;
  assign hreadyout            = hreadyout_r;
  assign hresp                = hresp_r;
  assign nand_mode_region_two = nand_mode_r;
  assign ecc_running          = ecc_start_r;

endmodule

// ==== design/nrec_pkg.sv ====
// Package of constants and types for the NAND region ECC control block
package nrec_pkg;

  // Byte addresses of the registers (one aligned word each)
  localparam logic [7:0] NREC_OFS_CONTROL = 8'h00;  // nand_region_control
  localparam logic [7:0] NREC_OFS_STATUS  = 8'h04;  // nand_wait_status
  localparam logic [7:0] NREC_OFS_PARITY  = 8'h08;  // nand_region_parity_code
  localparam logic [7:0] NREC_OFS_CONFIG  = 8'h0C;  // nand_ecc_config (data path width)

  // Field positions
  localparam int NREC_BIT_NAND_MODE  = 0;   // nand_mode_region_two in control
  localparam int NREC_BIT_ECC_START  = 8;   // ecc_start_region_two in control
  localparam int NREC_BIT_RAW_WAIT   = 0;   // raw_wait_level in status
  localparam int NREC_BIT_WIDE_PATH  = 0;   // 16-bit data path select in config
  localparam int NREC_ODD_LSB        = 16;  // Odd parities in bits 27..16
  localparam int NREC_EVEN_LSB       = 0;   // Even parities in bits 11..0
  localparam int NREC_PAR_BITS       = 12;  // P1 up to P2048

  // Column bits per data path width
  localparam int NREC_COLS_NARROW    = 3;   // 8-bit path: P1..P4 over columns
  localparam int NREC_COLS_WIDE      = 4;   // 16-bit path: P1..P8 over columns

  // Reset values
  localparam logic [31:0] NREC_RST_CONTROL = 32'h0000_0000;
  localparam logic [11:0] NREC_RST_PARITY  = 12'h000;
  localparam logic [11:0] NREC_RST_ROW     = 12'h000;
  localparam logic        NREC_RST_WIDE    = 1'b0;

  // AHB-Lite transfer type bit that marks an active transfer
  localparam int NREC_HTRANS_ACTIVE = 1;

  // Bus slave states, Gray coded along idle -> read wait -> read done
  typedef enum logic [1:0] {
    NREC_ST_IDLE   = 2'b00,
    NREC_ST_RDWAIT = 2'b01,
    NREC_ST_RDDONE = 2'b11,
    NREC_ST_WRITE  = 2'b10
  } nrec_state_t;

  // One data unit moved between the memory interface and the NAND flash
  typedef struct packed {
    logic        valid;  // One-cycle strobe per byte or word transferred
    logic        cs2;    // Access targets chip_select_two region
    logic [15:0] data;   // Data unit; low byte used on an 8-bit path
  } nrec_access_t;

endpackage

// ==== design/nrec_parity_slice.sv ====
// One parity position (P of 2^N): odd and even contribution of one data unit
`timescale 1ns/1ps
module nrec_parity_slice #(
  parameter int N = 0
) (
  input  wire logic [15:0] data,
  input  wire logic [11:0] row,
  input  wire logic        wide,
  output      logic        odd_term,
  output      logic        even_term
);
  import nrec_pkg::*;

  // Position of a data bit is {row, column}; bit N of it picks odd or even
  always_comb begin
    int  cols;
    int  ridx;
    logic unit_par;
    cols      = wide ? NREC_COLS_WIDE : NREC_COLS_NARROW;
    ridx      = 0;
    unit_par  = wide ? ^data : ^data[7:0];
    odd_term  = 1'b0;
    even_term = 1'b0;
    if (N < cols) begin
      // Column parity over bit positions within the unit
      for (int j = 0; j < 16; j++) begin
        if (wide || j < 8) begin
          if (((j >> N) & 1) == 1) begin
            odd_term = odd_term ^ data[j];
          end else begin
            even_term = even_term ^ data[j];
          end
        end
      end
    end else begin
      // Row parity over the unit index
      ridx = N - cols;
      if (row[ridx]) begin
        odd_term = unit_par;
      end else begin
        even_term = unit_par;
      end
    end
  end

endmodule

// ==== testbench/nrec_top_sva.sv ====
// Checker of bus timing, control bits and read-back of nrec_top
`timescale 1ns/1ps
module nrec_top_chk (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ext_wait_input,
  input wire logic        nand_mode_region_two,
  input wire logic        ecc_running
);
  // Transfer taken, read taken, control write taken
  wire logic tk = hsel && htrans[1] && hready;
  wire logic rd = tk && !hwrite;
  wire logic wc = tk && hwrite && haddr[7:2] == 6'h00;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  chk_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  chk_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
  chk_mode_bit: assert property (wc |=> ##1 nand_mode_region_two == $past(hwdata[0]))
    else $error("mode bit not stored");
  chk_start_bit: assert property (wc |=> ##1 ecc_running == $past(hwdata[8]))
    else $error("start bit not stored");
  chk_mode_hold: assert property ($changed(nand_mode_region_two) |-> $past(wc, 2))
    else $error("mode changed without write");
  chk_wait_raw: assert property (rd && haddr[7:2] == 6'h01 |=> ##1 hrdata == {31'h0, $past(ext_wait_input)})
    else $error("status not raw wait level");
  chk_parity_resvd: assert property (rd && haddr[7:2] == 6'h02 |=> ##1 hrdata[31:28] == 4'h0 && hrdata[15:12] == 4'h0)
    else $error("parity reserved bits set");
  chk_unmapped_zero: assert property (rd && haddr[7:2] > 6'h03 |=> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind nrec_top nrec_top_chk i_chk (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .ext_wait_input(ext_wait_input), .nand_mode_region_two(nand_mode_region_two),
  .ecc_running(ecc_running));

// ==== testbench/nrec_flash_model.sv ====
// Behavioural NAND flash: streams data units and drives the wait pin
`timescale 1ns/1ps
module nrec_flash_model (
  input  wire logic          ref_clk,
  input  wire logic          run,
  input  wire logic          busy,
  output nrec_pkg::nrec_access_t nand_access,
  output logic               ext_wait_input
);
  import nrec_pkg::*;
  // Random unit each cycle while running; idle data stays random so stale values never match
  // Single driver per output: everything is set here, from the first edge on
  always @(posedge ref_clk) begin
    ext_wait_input <= busy;
    if (run) begin
      nand_access <= {1'($urandom), 1'($urandom), 16'($urandom)};
    end else begin
      nand_access.valid <= 1'b0;
      nand_access.cs2 <= 1'b0;
      nand_access.data <= 16'($urandom);
    end
  end
endmodule

// ==== testbench/nrec_top_test.sv ====
// Self-checking bench of nrec_top with a NAND flash model
`timescale 1ns/1ps
module nrec_top_test;
  import nrec_pkg::*;
  logic         ref_clk, reset_n, hsel, hwrite, run, busy;
  logic [31:0]  haddr, hwdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  wire  logic [31:0] hrdata;
  wire  logic   hreadyout, hresp, mode_o, ecc_o, wait_pin;
  nrec_access_t acc;
  int           mismatches, n_compared, e_idx;
  logic [23:0]  e_par;      // Expected odd (high) and even (low) parities
  logic         e_mode, e_ecc, e_wide;
  nrec_top i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_wait_input(wait_pin), .nand_access(acc),
    .nand_mode_region_two(mode_o), .ecc_running(ecc_o));
  nrec_flash_model i_flash (.ref_clk(ref_clk), .run(run), .busy(busy), .nand_access(acc),
    .ext_wait_input(wait_pin));
  // Clock of 100 ns
  always #50 ref_clk = ~ref_clk;
  // Parity update for one data unit at unit index idx
  function automatic logic [23:0] upd(logic [23:0] p, int idx, logic [15:0] d, logic w);
    int pos;
    for (int b = 0; b < (w ? 16 : 8); b++) begin
      if (d[b]) begin
        pos = idx * (w ? 16 : 8) + b;
        for (int n = 0; n < 12; n++) begin
          if (pos[n]) p[12+n] = ~p[12+n];
          else p[n] = ~p[n];
        end
      end
    end
    return p;
  endfunction
  // Expected parity follows every accepted unit
  always @(posedge ref_clk) begin
    if (acc.valid === 1'b1 && acc.cs2 === 1'b1 && e_mode && e_ecc) begin
      e_par = upd(e_par, e_idx, acc.data, e_wide);
      e_idx = (e_idx + 1) % 4096;
    end
  end
  task automatic print_verdict;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits for hready high at a rising edge, bounded
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // One single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a == NREC_OFS_CONTROL) begin
      e_mode = d[0];
      e_ecc = d[8];
      if (d[8]) begin
        e_par = '0;
        e_idx = 0;
      end
    end
    if (a == NREC_OFS_CONFIG) e_wide = d[0];
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask
  // Lets the flash stream for n cycles, with valid set at random, then settles
  task automatic stream(input int n);
    run <= 1'b1;
    repeat (n) @(posedge ref_clk);
    run <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Register view of the expected parities
  function automatic logic [31:0] preg(logic [23:0] p);
    return {4'h0, p[23:12], 4'h0, p[11:0]};
  endfunction
  // Hang guard
  initial begin
    #5000000;
    mismatches++;
    print_verdict();
  end
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run = 1'b0;
    busy = 1'b0;
    e_par = 24'h0;
    e_idx = 0;
    e_mode = 1'b0;
    e_ecc = 1'b0;
    e_wide = 1'b0;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'h662F));
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(NREC_OFS_CONTROL, 32'h0, "control");
    rd(NREC_OFS_PARITY, 32'h0, "parity");
    rd(NREC_OFS_CONFIG, 32'h0, "config");
    rd(8'h10, 32'h0, "unmapped");
    // Wait pin seen raw in both levels
    for (int i = 0; i < 4; i++) begin
      busy <= i[0];
      repeat (2) @(posedge ref_clk);
      rd(NREC_OFS_STATUS, {31'h0, i[0]}, "status");
    end
    wr(NREC_OFS_CONTROL, 32'hFFFF_FFFF);
    rd(NREC_OFS_CONTROL, 32'h0000_0101, "control");
    wr(NREC_OFS_PARITY, 32'hFFFF_FFFF);
    wr(NREC_OFS_STATUS, 32'hFFFF_FFFF);
    rd(NREC_OFS_PARITY, 32'h0, "parity");
    // Both data path widths: accumulate, stop, then mode off
    for (int w = 0; w < 2; w++) begin
      wr(NREC_OFS_CONFIG, 32'(w));
      rd(NREC_OFS_CONFIG, 32'(w), "config");
      wr(NREC_OFS_CONTROL, 32'h0000_0101);
      stream(300 + $urandom_range(0, 300));
      rd(NREC_OFS_PARITY, preg(e_par), "parity");
      wr(NREC_OFS_CONTROL, 32'h0000_0001);
      stream(20);
      rd(NREC_OFS_PARITY, preg(e_par), "parity held");
      wr(NREC_OFS_CONTROL, 32'h0000_0100);
      stream(20);
      rd(NREC_OFS_PARITY, 32'h0, "parity mode off");
    end
    print_verdict();
  end
endmodule
